// [pip_regs.sv]
// Peripheral interrupt enable, priority and reset-cause registers.
// Assumes a classic Wishbone master on clk_i and source flags from same-clock logic.
//
// The Wishbone slave port and the register addresses were left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module pip_regs #(
  parameter int PACKAGE_PINS = 100
) (
  // Clock, reset and clock enable.
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave.
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic             ack_o,
  output logic [31:0]      dat_o,
  // Peripheral sources.
  input  wire logic [7:0]  flags1_i,
  input  wire logic [7:0]  flags2_i,
  input  wire logic [7:0]  flags3_i,
  input  wire logic [7:0]  enable1_i,
  input  wire logic [7:0]  enable2_i,
  // Reset-cause events, one-cycle pulses that clear their flag.
  input  wire logic [5:0]  cause_evt_i,
  // Requests and block interrupt.
  output logic             irq_high_o,
  output logic             irq_low_o,
  output logic             prio_levels_o,
  output logic             irq_o
);

  // Implemented bits of the third group for this package.
  function automatic logic [7:0] group3_mask(input int pins);
    if (pins >= pip_pkg::PINS_LARGE) begin
      return pip_pkg::G3_MASK_LARGE;
    end else if (pins >= pip_pkg::PINS_MID) begin
      return pip_pkg::G3_MASK_MID;
    end else begin
      return pip_pkg::G3_MASK_SMALL;
    end
  endfunction : group3_mask

  // Word decode, shared by the read mux and the write strobes.
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] off);
    return adr == off;
  endfunction : hit

  localparam logic [7:0] G3_MASK = group3_mask(PACKAGE_PINS);

  typedef struct packed {
    logic        ack;
    logic [31:0] rdata;
    logic [7:0]  en3;
    logic [7:0]  prio1;
    logic [7:0]  prio2;
    logic [7:0]  prio3;
    logic [7:0]  reset_cause_control;
    logic [7:0]  gctl;
    logic        irq_high;
    logic        irq_low;
    logic        prev_high;
    logic        prev_low;
  } pip_regs_state_type;

  pip_regs_state_type state_ff;
  pip_regs_state_type nxt_state;

  logic [2:0]               grp_high;
  logic [2:0]               grp_low;
  logic [7:0]               grp_flags  [3];
  logic [7:0]               grp_enable [3];
  logic [7:0]               grp_prio   [3];
  logic                     prio_on;
  logic                     wr_take;
  logic                     bus_req;
  logic                     mapped;
  logic [pip_pkg::EVT_W-1:0] evt_set;
  logic [pip_pkg::EVT_W-1:0] evt_status;
  logic [pip_pkg::EVT_W-1:0] evt_enable;
  logic                     evt_irq;
  logic                     req_high;
  logic                     req_low;

  assign prio_on = state_ff.reset_cause_control[pip_pkg::RESET_CAUSE_CONTROL_PRIO_EN_BIT];

  // Group inputs; the third group only sees bits that this package has.
  assign grp_flags[0]  = flags1_i;
  assign grp_flags[1]  = flags2_i;
  assign grp_flags[2]  = flags3_i & G3_MASK;
  assign grp_enable[0] = enable1_i;
  assign grp_enable[1] = enable2_i;
  assign grp_enable[2] = state_ff.en3;
  assign grp_prio[0]   = state_ff.prio1;
  assign grp_prio[1]   = state_ff.prio2;
  assign grp_prio[2]   = state_ff.prio3;

  // One router per source group.
  for (genvar g = 0; g < 3; g++) begin : g_route
    pip_route u_route (
      .flags_i   (grp_flags[g]),
      .enable_i  (grp_enable[g]),
      .prio_i    (grp_prio[g]),
      .prio_on_i (prio_on),
      .high_o    (grp_high[g]),
      .low_o     (grp_low[g])
    );
  end

  // In single-level mode the peripheral global enable gates every request,
  // so firmware that forgets it sees no request on irq_high_o or irq_low_o.
  always_comb begin
    if (prio_on) begin
      req_high = |grp_high;
      req_low  = |grp_low;
    end else begin
      req_high = (|grp_high) & state_ff.gctl[pip_pkg::GCTL_PERIPH_BIT];
      req_low  = 1'b0;
    end
  end

  // Bus handshake terms. The write lands on the edge where the master
  // sees ack high, which is the edge after ack was registered.
  assign bus_req = cyc_i & stb_i;
  assign wr_take = bus_req & we_i & state_ff.ack & sel_i[0];
  assign mapped  = hit(adr_i, pip_pkg::OFF_EN3)   | hit(adr_i, pip_pkg::OFF_PRIO1) |
                   hit(adr_i, pip_pkg::OFF_PRIO2) | hit(adr_i, pip_pkg::OFF_PRIO3) |
                   hit(adr_i, pip_pkg::OFF_RESET_CAUSE_CONTROL)  | hit(adr_i, pip_pkg::OFF_GCTL)  |
                   hit(adr_i, pip_pkg::OFF_ISTAT) | hit(adr_i, pip_pkg::OFF_ICLR)  |
                   hit(adr_i, pip_pkg::OFF_IEN);

  // Block events: new requests on either level, a write that drops the
  // reserved bit, and a completed access to an unmapped word.
  always_comb begin
    evt_set = '0;
    evt_set[pip_pkg::EVT_HIGH] = req_high & ~state_ff.prev_high;
    evt_set[pip_pkg::EVT_LOW]  = req_low & ~state_ff.prev_low;
    evt_set[pip_pkg::EVT_RSVD] = wr_take & hit(adr_i, pip_pkg::OFF_PRIO2) &
                                 ~dat_i[pip_pkg::PRIO2_RSVD_BIT];
    evt_set[pip_pkg::EVT_ADDR] = bus_req & state_ff.ack & ~mapped;
  end

  pip_evt u_evt (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .ce_i     (ce_i),
    .set_i    (evt_set),
    .clr_we_i (wr_take & hit(adr_i, pip_pkg::OFF_ICLR)),
    .en_we_i  (wr_take & hit(adr_i, pip_pkg::OFF_IEN)),
    .wdata_i  (dat_i[pip_pkg::EVT_W-1:0]),
    .status_o (evt_status),
    .enable_o (evt_enable),
    .irq_o    (evt_irq)
  );

  // Next state: bus answer, register writes, cause flags and requests.
  always_comb begin
    nxt_state = state_ff;

    // Ack rises one edge after the request and falls on the next edge.
    nxt_state.ack   = bus_req & ~state_ff.ack;
    nxt_state.rdata = '0;
    if (bus_req & ~state_ff.ack & ~we_i) begin
      unique case (1'b1)
        hit(adr_i, pip_pkg::OFF_EN3):   nxt_state.rdata[7:0] = state_ff.en3;
        hit(adr_i, pip_pkg::OFF_PRIO1): nxt_state.rdata[7:0] = state_ff.prio1;
        hit(adr_i, pip_pkg::OFF_PRIO2): nxt_state.rdata[7:0] = state_ff.prio2 & ~pip_pkg::PRIO2_UNIMPL;
        hit(adr_i, pip_pkg::OFF_PRIO3): nxt_state.rdata[7:0] = state_ff.prio3;
        hit(adr_i, pip_pkg::OFF_RESET_CAUSE_CONTROL):  nxt_state.rdata[7:0] = state_ff.reset_cause_control;
        hit(adr_i, pip_pkg::OFF_GCTL):  nxt_state.rdata[7:0] = state_ff.gctl;
        hit(adr_i, pip_pkg::OFF_ISTAT): nxt_state.rdata[pip_pkg::EVT_W-1:0] = evt_status;
        hit(adr_i, pip_pkg::OFF_IEN):   nxt_state.rdata[pip_pkg::EVT_W-1:0] = evt_enable;
        default:                        nxt_state.rdata = '0;
      endcase
    end

    // Register writes from the low byte lane.
    if (wr_take) begin
      if (hit(adr_i, pip_pkg::OFF_EN3)) begin
        // Read-only and absent bits keep their value of zero.
        nxt_state.en3 = dat_i[7:0] & ~pip_pkg::EN3_RO_MASK & G3_MASK;
      end
      if (hit(adr_i, pip_pkg::OFF_PRIO1)) begin
        nxt_state.prio1 = dat_i[7:0];
      end
      if (hit(adr_i, pip_pkg::OFF_PRIO2)) begin
        nxt_state.prio2 = dat_i[7:0] & ~pip_pkg::PRIO2_UNIMPL;
      end
      if (hit(adr_i, pip_pkg::OFF_PRIO3)) begin
        nxt_state.prio3 = dat_i[7:0] & G3_MASK;
      end
      if (hit(adr_i, pip_pkg::OFF_RESET_CAUSE_CONTROL)) begin
        // Watchdog and power-down flags and bit 6 ignore software.
        nxt_state.reset_cause_control = (dat_i[7:0] & pip_pkg::RESET_CAUSE_CONTROL_RW_MASK) |
                         (state_ff.reset_cause_control & ~pip_pkg::RESET_CAUSE_CONTROL_RW_MASK);
      end
      if (hit(adr_i, pip_pkg::OFF_GCTL)) begin
        nxt_state.gctl = {7'h00, dat_i[pip_pkg::GCTL_PERIPH_BIT]};
      end
    end

    // A cause event clears its flag and wins over a software write
    // in the same cycle, so the cause is never hidden.
    for (int i = 0; i < 6; i++) begin
      if (cause_evt_i[i]) begin
        nxt_state.reset_cause_control[i] = 1'b0;
      end
    end

    // Registered requests and edge history.
    nxt_state.irq_high  = req_high;
    nxt_state.irq_low   = req_low;
    nxt_state.prev_high = req_high;
    nxt_state.prev_low  = req_low;
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{
        ack:       1'b0,
        rdata:     32'h0000_0000,
        en3:       pip_pkg::EN3_RST,
        prio1:     pip_pkg::PRIO_RST,
        prio2:     pip_pkg::PRIO2_RST,
        prio3:     pip_pkg::PRIO_RST & G3_MASK,
        reset_cause_control:      pip_pkg::RESET_CAUSE_CONTROL_RST,
        gctl:      pip_pkg::GCTL_RST,
        irq_high:  1'b0,
        irq_low:   1'b0,
        prev_high: 1'b0,
        prev_low:  1'b0
      };
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  // Outputs come straight from the state register, except irq_o, which comes from the u_evt state register.
  assign ack_o         = state_ff.ack;
  assign dat_o         = state_ff.rdata;
  assign irq_high_o    = state_ff.irq_high;
  assign irq_low_o     = state_ff.irq_low;
  assign prio_levels_o = state_ff.reset_cause_control[pip_pkg::RESET_CAUSE_CONTROL_PRIO_EN_BIT];
  assign irq_o         = evt_irq;

endmodule : pip_regs

`default_nettype wire

// [pip_pkg.sv]
// Package for the peripheral interrupt priority register block.
// Assumes a byte-addressed classic Wishbone slave with 32-bit data words.
package pip_pkg;

  // Bus geometry.
  localparam int ADR_W = 8;
  localparam int DAT_W = 32;
  localparam int REG_W = 8;

  // Register byte offsets, one aligned word each.
  localparam logic [7:0] OFF_EN3   = 8'h00;
  localparam logic [7:0] OFF_PRIO1 = 8'h04;
  localparam logic [7:0] OFF_PRIO2 = 8'h08;
  localparam logic [7:0] OFF_PRIO3 = 8'h0C;
  localparam logic [7:0] OFF_RESET_CAUSE_CONTROL  = 8'h10;
  localparam logic [7:0] OFF_GCTL  = 8'h14;
  localparam logic [7:0] OFF_ISTAT = 8'h18;
  localparam logic [7:0] OFF_ICLR  = 8'h1C;
  localparam logic [7:0] OFF_IEN   = 8'h20;

  // Reset values.
  localparam logic [7:0] EN3_RST   = 8'h00;
  localparam logic [7:0] PRIO_RST  = 8'hFF;
  localparam logic [7:0] PRIO2_RST = 8'hFB;
  localparam logic [7:0] RESET_CAUSE_CONTROL_RST  = 8'h3C;
  localparam logic [7:0] GCTL_RST  = 8'h00;
  localparam logic [3:0] IEN_RST   = 4'h0;

  // Field masks and positions.
  localparam logic [7:0] EN3_RO_MASK      = 8'h30;
  localparam logic [7:0] PRIO2_UNIMPL     = 8'h04;
  localparam int         PRIO2_RSVD_BIT   = 4;
  localparam logic [7:0] RESET_CAUSE_CONTROL_RW_MASK     = 8'hB3;
  localparam int         RESET_CAUSE_CONTROL_PRIO_EN_BIT = 7;
  localparam int         RESET_CAUSE_CONTROL_CM_BIT      = 5;
  localparam int         RESET_CAUSE_CONTROL_RI_BIT      = 4;
  localparam int         RESET_CAUSE_CONTROL_TO_BIT      = 3;
  localparam int         RESET_CAUSE_CONTROL_PD_BIT      = 2;
  localparam int         RESET_CAUSE_CONTROL_POR_BIT     = 1;
  localparam int         RESET_CAUSE_CONTROL_BOR_BIT     = 0;
  localparam int         GCTL_PERIPH_BIT  = 0;

  // Implemented bits of the third source group per package size.
  localparam int         PINS_LARGE = 100;
  localparam int         PINS_MID   = 80;
  localparam logic [7:0] G3_MASK_LARGE = 8'hFF;
  localparam logic [7:0] G3_MASK_MID   = 8'h3F;
  localparam logic [7:0] G3_MASK_SMALL = 8'h0F;

  // Block event status bits.
  localparam int EVT_W    = 4;
  localparam int EVT_HIGH = 0;
  localparam int EVT_LOW  = 1;
  localparam int EVT_RSVD = 2;
  localparam int EVT_ADDR = 3;

endpackage : pip_pkg

// [pip_route.sv]
// Request router for one group of eight peripheral sources.
// Assumes flags, enables and priorities all come from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module pip_route (
  // Source state.
  input  wire logic [7:0] flags_i,
  input  wire logic [7:0] enable_i,
  input  wire logic [7:0] prio_i,
  // Mode.
  input  wire logic       prio_on_i,
  // Requests.
  output logic            high_o,
  output logic            low_o
);

  logic [7:0] pend;

  // A source requests when its flag and enable are both set; its priority bit
  // picks the level only while priority levels are on.
  always_comb begin
    pend = flags_i & enable_i;
    if (prio_on_i) begin
      high_o = |(pend & prio_i);
      low_o  = |(pend & ~prio_i);
    end else begin
      high_o = |pend;
      low_o  = 1'b0;
    end
  end

endmodule : pip_route

`default_nettype wire

// [pip_evt.sv]
// Sticky event status with enable mask and one level interrupt.
// Assumes set pulses and register strobes come from the same clock domain.
`timescale 1ns/1ps
`default_nettype none

module pip_evt (
  // Clock and reset.
  input  wire logic                    clk_i,
  input  wire logic                    rst_i,
  input  wire logic                    ce_i,
  // Events and software access.
  input  wire logic [pip_pkg::EVT_W-1:0] set_i,
  input  wire logic                    clr_we_i,
  input  wire logic                    en_we_i,
  input  wire logic [pip_pkg::EVT_W-1:0] wdata_i,
  // State.
  output logic [pip_pkg::EVT_W-1:0]    status_o,
  output logic [pip_pkg::EVT_W-1:0]    enable_o,
  output logic                         irq_o
);

  typedef struct packed {
    logic [pip_pkg::EVT_W-1:0] status;
    logic [pip_pkg::EVT_W-1:0] enable;
    logic                      irq;
  } pip_evt_state_type;

  pip_evt_state_type state_ff;
  pip_evt_state_type nxt_state;

  // A set arriving with a clear wins, so no event is lost.
  always_comb begin
    nxt_state = state_ff;
    if (clr_we_i) begin
      nxt_state.status = state_ff.status & ~wdata_i;
    end
    nxt_state.status = nxt_state.status | set_i;
    if (en_we_i) begin
      nxt_state.enable = wdata_i;
    end
    nxt_state.irq = |(nxt_state.status & nxt_state.enable);
  end

  // State register, frozen while the clock enable is low.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_ff <= '{status: '0, enable: pip_pkg::IEN_RST, irq: 1'b0};
    end else if (ce_i) begin
      state_ff <= nxt_state;
    end
  end

  assign status_o = state_ff.status;
  assign enable_o = state_ff.enable;
  assign irq_o    = state_ff.irq;

endmodule : pip_evt

`default_nettype wire

// [pip_regs_props.sv]
// Concurrent checks for the peripheral interrupt priority register block.
// Assumes it is bound to pip_regs and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none

module pip_regs_props #(
  parameter int PACKAGE_PINS = 100
) (
  // Clock and reset.
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  // Wishbone slave.
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic        ack_o,
  input wire logic [31:0] dat_o,
  // Sources and requests.
  input wire logic [7:0]  flags1_i,
  input wire logic [7:0]  flags2_i,
  input wire logic [7:0]  flags3_i,
  input wire logic [7:0]  enable1_i,
  input wire logic [7:0]  enable2_i,
  input wire logic [5:0]  cause_evt_i,
  input wire logic        irq_high_o,
  input wire logic        irq_low_o,
  input wire logic        prio_levels_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  // Decoded strobes, kept apart so each property reads as one relation.
  wire logic rd_ack  = ack_o && !we_i;
  wire logic wr_reset_cause_control = cyc_i && stb_i && we_i && ack_o && sel_i[0] && (adr_i == pip_pkg::OFF_RESET_CAUSE_CONTROL);

  a_ack_pulse: assert property (ack_o |=> !ack_o) else $error("ack held past one cycle");
  a_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("request left unanswered");
  a_en3_ro_zero: assert property (
    rd_ack && adr_i == pip_pkg::OFF_EN3 |-> dat_o[5:4] == 2'h0 && dat_o[31:8] == 24'h0)
    else $error("read-only enable bits not zero");
  a_prio2_gap_zero: assert property (
    rd_ack && adr_i == pip_pkg::OFF_PRIO2 |-> !dat_o[2]) else $error("priority gap bit set");
  a_reset_cause_control_gap_zero: assert property (
    rd_ack && adr_i == pip_pkg::OFF_RESET_CAUSE_CONTROL |-> !dat_o[6]) else $error("reset-cause gap bit set");
  a_single_no_low: assert property (
    !prio_levels_o && !$past(prio_levels_o) |-> !irq_low_o) else $error("low request in single level");
  a_prio_en_set: assert property (
    wr_reset_cause_control && dat_i[7] |-> ##[1:2] prio_levels_o) else $error("priority levels not turned on");
  a_prio_en_clr: assert property (
    wr_reset_cause_control && !dat_i[7] |-> ##[1:2] !prio_levels_o) else $error("priority levels not turned off");
  a_no_flag_quiet: assert property (
    $past(flags1_i | flags2_i | flags3_i) == 8'h00 |-> !irq_high_o && !irq_low_o)
    else $error("request without any flag");

  // Main scenarios reached.
  c_low_req: cover property (irq_low_o);
  c_block_irq: cover property (irq_o);
  c_prio_on: cover property ($rose(prio_levels_o));
endmodule : pip_regs_props

bind pip_regs pip_regs_props #(.PACKAGE_PINS(PACKAGE_PINS)) u_props (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o),
  .dat_o(dat_o), .flags1_i(flags1_i), .flags2_i(flags2_i), .flags3_i(flags3_i), .enable1_i(enable1_i),
  .enable2_i(enable2_i), .cause_evt_i(cause_evt_i), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o),
  .prio_levels_o(prio_levels_o), .irq_o(irq_o));

`default_nettype wire

// [tb_top.sv]
// Self-checking bench for the peripheral interrupt priority register block.
// Assumes pip_pkg and pip_regs are compiled first; the bench is the bus master.
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic        clk_i       = 1'b0;
  logic        rst_i       = 1'b1;
  logic        ce_i        = 1'b1;
  logic        cyc_i       = 1'b0;
  logic        stb_i       = 1'b0;
  logic        we_i        = 1'b0;
  logic [7:0]  adr_i       = 8'h00;
  logic [3:0]  sel_i       = 4'h0;
  logic [31:0] dat_i       = 32'h0;
  logic [7:0]  flags1_i    = 8'h00;
  logic [7:0]  flags2_i    = 8'h00;
  logic [7:0]  flags3_i    = 8'h00;
  logic [7:0]  enable1_i   = 8'h00;
  logic [7:0]  enable2_i   = 8'h00;
  logic [5:0]  cause_evt_i = 6'h00;
  logic        ack_o;
  logic [31:0] dat_o;
  logic        irq_high_o;
  logic        irq_low_o;
  logic        prio_levels_o;
  logic        irq_o;
  int          mismatches  = 0;
  int          check_count = 0;

  // Free-running 10 MHz clock.
  always #50 clk_i = ~clk_i;

  pip_regs #(.PACKAGE_PINS(100)) dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .ack_o(ack_o), .dat_o(dat_o),
    .flags1_i(flags1_i), .flags2_i(flags2_i), .flags3_i(flags3_i), .enable1_i(enable1_i),
    .enable2_i(enable2_i), .cause_evt_i(cause_evt_i), .irq_high_o(irq_high_o), .irq_low_o(irq_low_o),
    .prio_levels_o(prio_levels_o), .irq_o(irq_o));

  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // One classic cycle; the wait is bounded so a silent slave cannot hang the run.
  task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [31:0] r);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= 4'h1;
    dat_i <= {24'h0, d};
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    r = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
    if (n >= 20) chk(32'h0, 32'h1);
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    logic [31:0] r;
    bus(1'b0, a, 8'h00, r);
    chk(r, {24'h0, e});
  endtask : rd

  // Requests are registered, so let writes and flag changes settle first.
  task automatic req(input logic h, input logic l);
    repeat (3) @(posedge clk_i);
    chk({30'h0, irq_high_o, irq_low_o}, {30'h0, h, l});
  endtask : req

  task automatic t_reset_values;
    rd(pip_pkg::OFF_EN3, 8'h00);
    rd(pip_pkg::OFF_PRIO1, 8'hFF);
    rd(pip_pkg::OFF_PRIO2, 8'hFB);
    rd(pip_pkg::OFF_PRIO3, 8'hFF);
    rd(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h3C);
    chk({31'h0, prio_levels_o}, 32'h0);
  endtask : t_reset_values

  task automatic t_field_access;
    wr(pip_pkg::OFF_EN3, 8'hFF);
    rd(pip_pkg::OFF_EN3, 8'hCF);
    wr(pip_pkg::OFF_PRIO2, 8'hFF);
    rd(pip_pkg::OFF_PRIO2, 8'hFB);
    wr(pip_pkg::OFF_PRIO2, 8'h10);
    rd(pip_pkg::OFF_PRIO2, 8'h10);
    wr(pip_pkg::OFF_PRIO1, 8'hA5);
    rd(pip_pkg::OFF_PRIO1, 8'hA5);
    wr(pip_pkg::OFF_PRIO1, 8'hFF);
    wr(pip_pkg::OFF_PRIO3, 8'h3C);
    rd(pip_pkg::OFF_PRIO3, 8'h3C);
  endtask : t_field_access

  // A watchdog event pulse clears its flag only.
  task automatic t_cause_flags;
    @(posedge clk_i);
    cause_evt_i <= 6'h08;
    @(posedge clk_i);
    cause_evt_i <= 6'h00;
    rd(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h34);
  endtask : t_cause_flags

  task automatic t_levels;
    flags1_i  <= 8'h01;
    enable1_i <= 8'h01;
    req(1'b0, 1'b0);
    wr(pip_pkg::OFF_GCTL, 8'h01);
    req(1'b1, 1'b0);
    wr(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'hFF);
    rd(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'hB7);
    chk({31'h0, prio_levels_o}, 32'h1);
    req(1'b1, 1'b0);
    wr(pip_pkg::OFF_PRIO1, 8'hFE);
    req(1'b0, 1'b1);
    wr(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h00);
    req(1'b1, 1'b0);
    rd(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h04);
  endtask : t_levels

  // A third-group source follows its own priority bit once levels are on.
  task automatic t_group3;
    flags1_i <= 8'h00;
    flags3_i <= 8'h01;
    req(1'b1, 1'b0);
    wr(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h80);
    req(1'b0, 1'b1);
    wr(pip_pkg::OFF_PRIO3, 8'h3D);
    req(1'b1, 1'b0);
    wr(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h00);
    rd(pip_pkg::OFF_RESET_CAUSE_CONTROL, 8'h04);
  endtask : t_group3

  // Unmapped access raises the block event; enabled, masked and cleared.
  task automatic t_block_irq;
    wr(pip_pkg::OFF_ICLR, 8'h0F);
    wr(pip_pkg::OFF_IEN, 8'h08);
    rd(8'h40, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h1);
    rd(pip_pkg::OFF_ISTAT, 8'h08);
    wr(pip_pkg::OFF_ICLR, 8'h08);
    wr(pip_pkg::OFF_IEN, 8'h00);
    rd(8'h40, 8'h00);
    repeat (3) @(posedge clk_i);
    chk({31'h0, irq_o}, 32'h0);
    rd(pip_pkg::OFF_ISTAT, 8'h08);
  endtask : t_block_irq

  task automatic give_verdict;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : give_verdict

  // Main sequence.
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset_values();
    t_field_access();
    t_cause_flags();
    t_levels();
    t_group3();
    t_block_irq();
    give_verdict();
  end

  // The whole run needs about 150 cycles; this limit cuts a hang short.
  initial begin
    repeat (3000) @(posedge clk_i);
    mismatches++;
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire
